// file: logic/ifc_counter.v
// intermediate frequency counter: input select, gate timing, 16-bit count
`timescale 1ns/10ps
`include "ifc_regs.vh"
module ifc_counter #(
    parameter CYCLES_PER_MS = `IFC_MS_NS / `IFC_CLK_PERIOD_NS
) (
    input  wire                     ref_clk_i,
    input  wire                     rst_i,
    input  wire [`IFC_ADDR_W-1:0]   reg_addr_i,
    input  wire                     reg_wr_i,
    input  wire [3:0]               reg_wdata_i,
    input  wire                     reg_rd_i,
    output wire [3:0]               reg_rdata_o,
    input  wire [`IFC_PADDR_W-1:0]  get_addr_i,
    input  wire                     get_i,
    output wire [`IFC_COUNT_W-1:0]  dbf_o,
    input  wire                     shared_port_pin_i,
    input  wire                     am_port_pin_i,
    output wire                     shared_pin_counter_o,
    output wire                     am_pin_counter_o,
    output wire                     gate_open_o
);
    // tick period cut to the timebase width on purpose
    localparam integer           TICK_LAST_I = CYCLES_PER_MS - 1;
    localparam [`IFC_TICK_W-1:0] TICK_LAST   = TICK_LAST_I[`IFC_TICK_W-1:0];

    // gate sequencer states
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_WAIT = 2'b01;
    localparam [1:0] ST_OPEN = 2'b10;

    reg  [3:0]               mode_r;
    reg  [3:0]               rdata_r;
    reg  [`IFC_COUNT_W-1:0]  dbf_r;
    reg  [`IFC_COUNT_W-1:0]  count_r;
    reg  [`IFC_COUNT_W-1:0]  count_nxt;
    reg  [`IFC_TICK_W-1:0]   tick_cnt_r;
    reg                      tick_r;
    reg  [1:0]               state_r;
    reg  [1:0]               state_nxt;
    reg  [3:0]               ms_left_r;
    reg  [3:0]               ms_left_nxt;
    reg                      flag_r;
    reg                      flag_nxt;
    reg                      half_r;
    reg                      half_nxt;

    wire       shared_rise;
    wire       am_rise;
    wire [1:0] count_function;
    wire [1:0] gate_time;
    wire       func_on;
    wire       fm_count_mode;
    wire       am_count_mode;
    wire       gate_is_open_code;
    wire       wr_ctrl;
    wire       count_start_bit;
    wire       count_clear_bit;
    wire       gate_open_flag;
    wire       gate_now;
    wire       in_rise;

    // gate length in 1 ms ticks for a fixed gate code
    function [3:0] gate_ms;
        input [1:0] code;
        begin
            case (code)
                `IFC_GT_1MS: gate_ms = `IFC_MS_1;
                `IFC_GT_4MS: gate_ms = `IFC_MS_4;
                `IFC_GT_8MS: gate_ms = `IFC_MS_8;
                default:     gate_ms = `IFC_MS_1;
            endcase
        end
    endfunction

    // synchronised rising edges of the two input pins
    ifc_edge_sync u_sync_shared (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .pin_i     (shared_port_pin_i),
        .rise_o    (shared_rise)
    );

    ifc_edge_sync u_sync_am (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .pin_i     (am_port_pin_i),
        .rise_o    (am_rise)
    );

    // mode field decode
    assign count_function = {mode_r[`IFC_FUNC_HI], mode_r[`IFC_FUNC_LO]};
    assign gate_time      = {mode_r[`IFC_GATE_HI], mode_r[`IFC_GATE_LO]};
    assign func_on        = (count_function != `IFC_FUNC_OFF);
    assign fm_count_mode  = (count_function == `IFC_FUNC_FM_SH);
    assign am_count_mode  = (count_function == `IFC_FUNC_AM_DED) |
                            (count_function == `IFC_FUNC_AM_SH);
    assign gate_is_open_code = (gate_time == `IFC_GT_OPEN);

    // pin routing: which pin is given to the counter amplifier
    assign shared_pin_counter_o = fm_count_mode |
                                  (count_function == `IFC_FUNC_AM_SH);
    assign am_pin_counter_o     = (count_function == `IFC_FUNC_AM_DED);
    assign in_rise = am_pin_counter_o ? am_rise :
                     (shared_pin_counter_o ? shared_rise : 1'b0);

    // control register write strobes
    assign wr_ctrl         = reg_wr_i & (reg_addr_i == `IFC_ADDR_CTRL);
    assign count_start_bit = wr_ctrl & reg_wdata_i[`IFC_CTRL_START];
    assign count_clear_bit = wr_ctrl & reg_wdata_i[`IFC_CTRL_CLEAR];

    // gate is open in the timed window, or at once for the open code
    assign gate_now = func_on & ((state_r == ST_OPEN) | gate_is_open_code);
    assign gate_open_flag = flag_r | (func_on & gate_is_open_code);
    assign gate_open_o = gate_now;

    // mode register
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            mode_r <= `IFC_MODE_RESET;
        end else if (reg_wr_i && (reg_addr_i == `IFC_ADDR_MODE)) begin
            mode_r <= reg_wdata_i;
        end
    end

    // free running 1 kHz timebase, one-cycle tick each time the count wraps
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            tick_cnt_r <= {`IFC_TICK_W{1'b0}};
            tick_r     <= 1'b0;
        end else if (tick_cnt_r == TICK_LAST) begin
            tick_cnt_r <= {`IFC_TICK_W{1'b0}};
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
            tick_r     <= 1'b0;
        end
    end

    // gate sequencer
    always @* begin
        state_nxt   = state_r;
        ms_left_nxt = ms_left_r;
        flag_nxt    = flag_r;
        case (state_r)
            ST_IDLE: begin
                if (count_start_bit && func_on && !gate_is_open_code) begin
                    state_nxt = ST_WAIT;
                    flag_nxt  = 1'b1;
                end
            end
            ST_WAIT: begin
                if (tick_r) begin
                    state_nxt   = ST_OPEN;
                    ms_left_nxt = gate_ms(gate_time);
                end
            end
            ST_OPEN: begin
                if (tick_r) begin
                    ms_left_nxt = ms_left_r - 1'b1;
                    if (ms_left_r == `IFC_MS_1) begin
                        state_nxt = ST_IDLE;
                        flag_nxt  = 1'b0;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                flag_nxt  = 1'b0;
            end
        endcase
        // leaving the counter function or taking the open code ends a timed gate
        if (!func_on || gate_is_open_code) begin
            state_nxt = ST_IDLE;
            flag_nxt  = 1'b0;
        end
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_r   <= ST_IDLE;
            ms_left_r <= 4'h0;
            flag_r    <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            ms_left_r <= ms_left_nxt;
            flag_r    <= flag_nxt;
        end
    end

    // counter with FM halving; clear write has priority over an edge
    always @* begin
        count_nxt = count_r;
        half_nxt  = half_r;
        if (count_clear_bit) begin
            count_nxt = {`IFC_COUNT_W{1'b0}};
            half_nxt  = 1'b0;
        end else if (gate_now && in_rise) begin
            if (fm_count_mode) begin
                half_nxt = ~half_r;
                if (half_r) begin
                    count_nxt = count_r + 1'b1;
                end
            end else begin
                count_nxt = count_r + 1'b1;
            end
        end
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            count_r <= {`IFC_COUNT_W{1'b0}};
            half_r  <= 1'b0;
        end else begin
            count_r <= count_nxt;
            half_r  <= half_nxt;
        end
    end

    // transfer of the count into the data buffer
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            dbf_r <= {`IFC_COUNT_W{1'b0}};
        end else if (get_i && (get_addr_i == `IFC_PADDR_COUNT)) begin
            dbf_r <= count_r;
        end
    end

    // register read data, one cycle after the read strobe
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_r <= 4'h0;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `IFC_ADDR_MODE: rdata_r <= mode_r;
                `IFC_ADDR_GATE: rdata_r <= {3'b000, gate_open_flag};
                default:        rdata_r <= 4'h0;
            endcase
        end
    end

    assign reg_rdata_o = rdata_r;
    assign dbf_o       = dbf_r;
endmodule // ifc_counter

// file: logic/ifc_regs.vh
// register map, field positions and timing constants of the frequency counter
`ifndef IFC_REGS_VH
`define IFC_REGS_VH

`define IFC_ADDR_W       7
`define IFC_ADDR_MODE    7'h62
`define IFC_ADDR_CTRL    7'h63
`define IFC_ADDR_GATE    7'h64
`define IFC_PADDR_W      7
`define IFC_PADDR_COUNT  7'h43

`define IFC_MODE_RESET   4'h0
`define IFC_FUNC_HI      3
`define IFC_FUNC_LO      2
`define IFC_GATE_HI      1
`define IFC_GATE_LO      0
`define IFC_CTRL_START   1
`define IFC_CTRL_CLEAR   0
`define IFC_STAT_GATE    0

`define IFC_FUNC_OFF     2'b00
`define IFC_FUNC_FM_SH   2'b01
`define IFC_FUNC_AM_DED  2'b10
`define IFC_FUNC_AM_SH   2'b11

`define IFC_GT_1MS       2'b00
`define IFC_GT_4MS       2'b01
`define IFC_GT_8MS       2'b10
`define IFC_GT_OPEN      2'b11

`define IFC_MS_1         4'h1
`define IFC_MS_4         4'h4
`define IFC_MS_8         4'h8

`define IFC_CLK_PERIOD_NS 10
`define IFC_MS_NS         1000000
`define IFC_TICK_W        17
`define IFC_COUNT_W       16

`endif

// file: logic/ifc_edge_sync.v
// two-stage pin synchroniser with rising edge detector
`timescale 1ns/10ps
module ifc_edge_sync (
    input  wire ref_clk_i,
    input  wire rst_i,
    input  wire pin_i,
    output wire rise_o
);
    reg meta_r;
    reg sync_r;
    reg last_r;

    // first stage feeds only the second; edge taken from later stages
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= pin_i;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign rise_o = sync_r & ~last_r;
endmodule // ifc_edge_sync

// file: tb/ifc_counter_monitor.sv
// checker of gate timing, pin selection and register read rules
`timescale 1ns/10ps
`include "ifc_regs.vh"
module ifc_counter_monitor #(
    parameter CYCLES_PER_MS = 20
) (
    input wire logic                    ref_clk_i,
    input wire logic                    rst_i,
    input wire logic [`IFC_ADDR_W-1:0]  reg_addr_i,
    input wire logic                    reg_wr_i,
    input wire logic [3:0]              reg_wdata_i,
    input wire logic                    reg_rd_i,
    input wire logic [3:0]              reg_rdata_o,
    input wire logic [`IFC_PADDR_W-1:0] get_addr_i,
    input wire logic                    get_i,
    input wire logic [15:0]             dbf_o,
    input wire logic                    shared_port_pin_i,
    input wire logic                    am_port_pin_i,
    input wire logic                    shared_pin_counter_o,
    input wire logic                    am_pin_counter_o,
    input wire logic                    gate_open_o
);
    localparam int LIM = CYCLES_PER_MS + 2;
    logic [3:0]  mode_r;
    logic [15:0] len_r;
    logic        fn_on;
    // shadow of the mode register and length of the open gate
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mode_r <= 4'h0;
        end else if (reg_wr_i && reg_addr_i == `IFC_ADDR_MODE) begin
            mode_r <= reg_wdata_i;
        end
        len_r <= gate_open_o ? len_r + 16'h0001 : 16'h0000;
    end
    assign fn_on = mode_r[3:2] != 2'b00;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_start;
        reg_wr_i && reg_addr_i == `IFC_ADDR_CTRL && reg_wdata_i[1] && fn_on
            && mode_r[1:0] != 2'b11 && !gate_open_o;
    endsequence
    sequence s_open;
        fn_on && mode_r[1:0] == 2'b11;
    endsequence
    property p_start_gate;
        s_start |-> ##[1:LIM] $rose(gate_open_o);
    endproperty
    property p_gate_len;
        $fell(gate_open_o) && fn_on && mode_r[1:0] != 2'b11 |-> len_r ==
            (mode_r[1:0] == 2'b00 ? 1 : mode_r[1:0] == 2'b01 ? 4 : 8) * CYCLES_PER_MS;
    endproperty
    property p_open;
        s_open ##1 s_open |-> gate_open_o;
    endproperty
    property p_off;
        !fn_on ##1 !fn_on |-> !gate_open_o;
    endproperty
    property p_pins;
        shared_pin_counter_o == mode_r[2] && am_pin_counter_o == (mode_r[3:2] == 2'b10);
    endproperty
    property p_flag;
        reg_rd_i && reg_addr_i == `IFC_ADDR_GATE && gate_open_o |=> reg_rdata_o[0];
    endproperty
    property p_unmapped;
        reg_rd_i && reg_addr_i != `IFC_ADDR_MODE && reg_addr_i != `IFC_ADDR_GATE
            |=> reg_rdata_o == 4'h0;
    endproperty
    property p_rst;
        $fell(rst_i) |-> !gate_open_o && !shared_pin_counter_o && !am_pin_counter_o;
    endproperty
    property p_dbf_hold;
        !(get_i && get_addr_i == `IFC_PADDR_COUNT) |=> $stable(dbf_o);
    endproperty
    a_start_gate: assert property (p_start_gate) else $error("gate did not open");
    a_gate_len: assert property (p_gate_len) else $error("wrong gate length");
    a_open: assert property (p_open) else $error("open code gate shut");
    a_off: assert property (p_off) else $error("gate open while off");
    a_pins: assert property (p_pins) else $error("pin selection wrong");
    a_flag: assert property (p_flag) else $error("flag low while open");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_rst: assert property (p_rst) else $error("outputs not cleared");
    a_dbf_hold: assert property (p_dbf_hold) else $error("buffer changed");
endmodule // ifc_counter_monitor
bind ifc_counter ifc_counter_monitor #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_mon (.*);

// file: tb/ifc_if_src.sv
// tuner intermediate frequency output: two square waves locked to the clock
`timescale 1ns/10ps
module ifc_if_src (
    input  wire logic ref_clk_i,
    output logic      shared_port_pin_o,
    output logic      am_port_pin_o
);
    logic [1:0] ph_r = 2'h0;
    // free-running divider feeding both pins, which the counter only reads
    always @(posedge ref_clk_i) begin
        ph_r <= ph_r + 2'h1;
    end
    assign shared_port_pin_o = ph_r[1]; // rises every 4 cycles
    assign am_port_pin_o = ph_r[0]; // rises every 2 cycles
endmodule // ifc_if_src

// file: tb/ifc_counter_tb_top.sv
// self-checking bench of the frequency counter
`timescale 1ns/10ps
`include "ifc_regs.vh"
module ifc_counter_tb_top;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [6:0]  reg_addr_i = 7'h00;
    logic        reg_wr_i = 1'b0;
    logic [3:0]  reg_wdata_i = 4'h0;
    logic        reg_rd_i = 1'b0;
    logic [3:0]  reg_rdata_o;
    logic [6:0]  get_addr_i = 7'h00;
    logic        get_i = 1'b0;
    logic [15:0] dbf_o;
    logic        sh_pin, am_pin, sh_cnt, am_cnt, gate_o;
    logic [3:0]  q;
    int          fails = 0;
    int          checked = 0;
    int          cyc = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    ifc_if_src u_src (.ref_clk_i(ref_clk_i), .shared_port_pin_o(sh_pin), .am_port_pin_o(am_pin));
    ifc_counter #(.CYCLES_PER_MS(20)) u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .get_addr_i(get_addr_i),
        .get_i(get_i), .dbf_o(dbf_o), .shared_port_pin_i(sh_pin), .am_port_pin_i(am_pin),
        .shared_pin_counter_o(sh_cnt), .am_pin_counter_o(am_cnt), .gate_open_o(gate_o));
    task summarize();
        if (fails == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [6:0] a, input logic [3:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task rd(input logic [6:0] a);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 q = reg_rdata_o;
    endtask
    task get(input logic [6:0] a);
        @(posedge ref_clk_i);
        get_addr_i <= a;
        get_i <= 1'b1;
        @(posedge ref_clk_i);
        get_i <= 1'b0;
        #1;
    endtask
    // clear, start, poll the flag, then transfer the count twice
    task run(input logic [3:0] m, input logic [15:0] exp);
        int n;
        wr(`IFC_ADDR_MODE, m);
        wr(`IFC_ADDR_CTRL, 4'h1);
        wr(`IFC_ADDR_CTRL, 4'h2);
        rd(`IFC_ADDR_GATE);
        chk({12'h000, q}, 16'h0001);
        n = 0;
        while (q[0] === 1'b1 && n < 40) begin
            repeat (5) @(posedge ref_clk_i);
            rd(`IFC_ADDR_GATE);
            n++;
        end
        chk({12'h000, q}, 16'h0000);
        get(`IFC_PADDR_COUNT);
        chk(dbf_o, exp);
        repeat (30) @(posedge ref_clk_i);
        get(`IFC_PADDR_COUNT);
        chk(dbf_o, exp);
    endtask
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd(`IFC_ADDR_MODE);
        chk({12'h000, q}, 16'h0000);
        for (int f = 0; f < 4; f++) begin
            wr(`IFC_ADDR_MODE, {f[1:0], 2'b00});
            rd(`IFC_ADDR_MODE);
            chk({12'h000, q}, {12'h000, f[1:0], 2'b00});
            chk({14'h0000, sh_cnt, am_cnt}, {14'h0000, f[0], f[1:0] == 2'b10});
        end
        rd(7'h10);
        chk({12'h000, q}, 16'h0000);
        run(4'b1000, 16'h000a);
        run(4'b0101, 16'h000a);
        run(4'b1110, 16'h0028);
        get(7'h42);
        chk(dbf_o, 16'h0028);
        wr(`IFC_ADDR_CTRL, 4'h1);
        get(`IFC_PADDR_COUNT);
        chk(dbf_o, 16'h0000);
        wr(`IFC_ADDR_MODE, 4'b1011);
        repeat (10) @(posedge ref_clk_i);
        chk({15'h0000, gate_o}, 16'h0001);
        rd(`IFC_ADDR_GATE);
        chk({12'h000, q}, 16'h0001);
        wr(`IFC_ADDR_CTRL, 4'h1);
        wr(`IFC_ADDR_MODE, 4'h0);
        get(`IFC_PADDR_COUNT);
        chk(dbf_o, 16'h0001);
        repeat (3) @(posedge ref_clk_i);
        chk({15'h0000, gate_o}, 16'h0000);
        summarize();
    end
endmodule // ifc_counter_tb_top
